// *** rtl/multifunction_timer_watchdog.v ***
/*
 Multifunction timer: prescaled 15-stage counter, overflow and periodic
 tick flags, four-stage software watchdog, plus an event status/mask pair.
 Assumes a CPU-side register port on the same clock, with one-cycle strobes
 and read data one cycle after the read strobe; program memory data for
 the watchdog address arrives on rom_data.
*/
// Our own choice: the address-and-strobe port.

`timescale 1ns/100ps
`include "timer_defines.vh"
`default_nettype none

module multifunction_timer_watchdog #(
  parameter HALT_ENABLE = 1
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [7:0]  rdata,
  input  wire [7:0]  rom_data,
  input  wire        halt_req,
  output wire        irq,
  output wire        timer_irq,
  output reg         watchdog_reset,
  output reg         por_busy
);

  // ===================================================================
  // Register decode
  function sel;
    input [15:0] a;
    input [15:0] target;
    begin
      sel = (a == target);
    end
  endfunction

  wire wr_ctl = wr_en & sel(addr, `ADDR_STATUS_CONTROL);
  wire wr_mask = wr_en & sel(addr, `ADDR_IRQ_MASK);
  wire wr_wdog = wr_en & sel(addr, `ADDR_WATCHDOG_CLEAR);
  wire rd_ctl = rd_en & sel(addr, `ADDR_STATUS_CONTROL);
  wire rd_mask = rd_en & sel(addr, `ADDR_IRQ_MASK);
  wire rd_wdog = rd_en & sel(addr, `ADDR_WATCHDOG_CLEAR);
  wire rd_cnt = rd_en & sel(addr, `ADDR_COUNT_LOW);

  // ===================================================================
  // Power-on sequencing
  reg [11:0] por_count;
  wire       por_done = (por_count == 12'hfdf);

  always @(posedge clk) begin
    if (rst) begin
      por_count <= 12'h000;
      por_busy  <= 1'b1;
    end else if (por_busy) begin
      if (por_done) begin
        por_busy <= 1'b0;
      end
      por_count <= por_count + 12'h001;
    end
  end

  // ===================================================================
  // Prescaler and 15-stage counter
  reg  [1:0]  prescale;
  reg  [14:0] count;
  wire        stage_step = (prescale == 2'h3);
  wire        wd_pulse;
  wire        release_clear = por_busy & por_done;

  always @(posedge clk) begin
    if (rst || release_clear) begin
      prescale <= 2'h0;
      count    <= 15'h0000;
    end else begin
      prescale <= prescale + 2'h1;
      if (stage_step) begin
        count <= count + 15'h0001;
      end
    end
  end

  // Low byte wraps every 256 * 4 = 1024 cycles
  wire ovf_event = stage_step & (count[7:0] == 8'hff) & ~por_busy;

  // ===================================================================
  // Status and control bits
  reg       overflow_flag;
  reg       tick_flag;
  reg       overflow_irq_enable;
  reg       tick_irq_enable;
  reg [1:0] rate_select;

  // Tick tap: carry out of stage 11 + rate
  reg [14:0] tap_mask;
  always @* begin
    case (rate_select)
      2'h0:    tap_mask = 15'h0fff;
      2'h1:    tap_mask = 15'h1fff;
      2'h2:    tap_mask = 15'h3fff;
      default: tap_mask = 15'h7fff;
    endcase
  end
  wire tick_event = stage_step & ((count & tap_mask) == tap_mask) & ~por_busy;

  always @(posedge clk) begin
    if (rst) begin
      overflow_flag       <= 1'b0;
      tick_flag           <= 1'b0;
      overflow_irq_enable <= 1'b0;
      tick_irq_enable     <= 1'b0;
      rate_select         <= `RATE_RESET;
    end else begin
      if (ovf_event) begin
        overflow_flag <= 1'b1;
      end else if (wr_ctl && wdata[`BIT_OVERFLOW_CLR]) begin
        overflow_flag <= 1'b0;
      end
      if (tick_event) begin
        tick_flag <= 1'b1;
      end else if (wr_ctl && wdata[`BIT_TICK_CLR]) begin
        tick_flag <= 1'b0;
      end
      if (wr_ctl) begin
        overflow_irq_enable <= wdata[`BIT_OVERFLOW_IE];
        tick_irq_enable     <= wdata[`BIT_TICK_IE];
        rate_select <= wdata[`BIT_RATE_HI:`BIT_RATE_LO];
      end
    end
  end

  assign timer_irq = (overflow_flag & overflow_irq_enable) |
                     (tick_flag & tick_irq_enable);

  // ===================================================================
  // Watchdog
  reg [3:0] wd_stages;
  reg       halted;

  always @(posedge clk) begin
    if (rst) begin
      halted <= 1'b0;
    end else if (halt_req && HALT_ENABLE != 0) begin
      halted <= 1'b1;
    end
  end

  // Eighth tick without a clear: 2^17 to 2^20 cycles depending on rate
  assign wd_pulse = tick_event & ~halted & (wd_stages == 4'h7);

  always @(posedge clk) begin
    if (rst || watchdog_reset) begin
      wd_stages      <= 4'h0;
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= wd_pulse;
      if (wr_wdog && !wdata[`BIT_WATCHDOG_CLEAR]) begin
        wd_stages <= 4'h0;
      end else if (tick_event && !halted) begin
        wd_stages <= wd_stages + 4'h1;
      end
    end
  end

  // ===================================================================
  // Event status and mask
  reg  [`EV_WIDTH-1:0] ev_status;
  reg  [`EV_WIDTH-1:0] ev_mask;
  wire [`EV_WIDTH-1:0] ev_set = {wd_pulse, tick_event, ovf_event};

  genvar g;
  generate
    for (g = 0; g < `EV_WIDTH; g = g + 1) begin : ev_bits
      always @(posedge clk) begin
        if (rst) begin
          ev_status[g] <= 1'b0;
        end else if (ev_set[g]) begin
          ev_status[g] <= 1'b1;
        end else if (rd_mask) begin
          ev_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (rst) begin
      ev_mask <= {`EV_WIDTH{1'b0}};
    end else if (wr_mask) begin
      ev_mask <= wdata[`EV_WIDTH-1:0];
    end
  end

  assign irq = |(ev_status & ev_mask);

  // ===================================================================
  // Read data, valid the cycle after the strobe
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_ctl) begin
      rdata <= {overflow_flag, tick_flag, overflow_irq_enable,
                tick_irq_enable, 2'b00, rate_select};
    end else if (rd_cnt) begin
      rdata <= count[7:0];
    end else if (rd_mask) begin
      rdata <= {ev_status, 1'b0, ev_mask, 1'b0};
    end else if (rd_wdog) begin
      rdata <= rom_data;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// *** shared/timer_defines.vh ***
/*
 Constants for the multifunction timer and watchdog: register offsets,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from design and bench files.
*/
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// =====================================================================
// Register offsets
`define ADDR_STATUS_CONTROL  16'h0008
`define ADDR_COUNT_LOW       16'h0009
`define ADDR_IRQ_MASK        16'h000a
`define ADDR_WATCHDOG_CLEAR  16'h07f0

// =====================================================================
// Status and control fields
`define BIT_OVERFLOW_FLAG    7
`define BIT_TICK_FLAG        6
`define BIT_OVERFLOW_IE      5
`define BIT_TICK_IE          4
`define BIT_OVERFLOW_CLR     3
`define BIT_TICK_CLR         2
`define BIT_RATE_HI          1
`define BIT_RATE_LO          0
`define RATE_RESET           2'h3
`define BIT_WATCHDOG_CLEAR   0

// =====================================================================
// Event status / mask layout
`define EV_OVERFLOW          0
`define EV_TICK              1
`define EV_WATCHDOG          2
`define EV_WIDTH             3

// =====================================================================
// Timing
`define COUNTER_STAGES       15
`define WATCHDOG_STAGES      4
`define POWER_ON_CYCLES      4064
`define PRESCALE_CYCLES      4
`define TICK_TAP_BASE        11

`endif

// *** testbench/program_memory_model.sv ***
/*
 Program memory seen by the timer for reads of the watchdog address.
 Assumes a combinational byte lookup on the register address.
*/
`timescale 1ns/100ps
`default_nettype none
module program_memory_model (
  input  wire logic [15:0] addr,
  output logic      [7:0]  rom_data
);
  // Byte pattern tied to the address, so a stale byte is visible
  assign rom_data = addr[7:0] ^ 8'h5a;
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
/*
 Register-level testbench for the multifunction timer.
 Assumes the program memory model and the bound checker.
*/
`timescale 1ns/100ps
`include "timer_defines.vh"
`default_nettype none
module tb;
  logic        clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, halt_req = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, d;
  wire  [7:0]  rdata, rom_data;
  wire         irq, timer_irq, watchdog_reset, por_busy;
  int          bad_count = 0, checked = 0, i;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
  // ===================================================================
  // Design, memory and clock
  multifunction_timer_watchdog i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rom_data(rom_data), .halt_req(halt_req),
    .irq(irq), .timer_irq(timer_irq), .watchdog_reset(watchdog_reset), .por_busy(por_busy));
  program_memory_model i_rom (.addr(addr), .rom_data(rom_data));
  initial begin
    forever #2 clk = ~clk;
  end
  // ===================================================================
  // Bus tasks and verdict
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk) begin wr_en <= 1'b1; addr <= a; wdata <= v; end
    @(posedge clk) wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk) begin rd_en <= 1'b1; addr <= a; end
    @(posedge clk) rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000 bad_count++;
    tally_and_finish;
  end
  // ===================================================================
  // Tests
  initial begin : main
    logic [7:0] c0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 5000 && por_busy !== 1'b0; i++) @(posedge clk);
    rd(`ADDR_STATUS_CONTROL); `CHK(d, 8'h03)
    rd(`ADDR_COUNT_LOW); c0 = d;
    repeat (6) @(posedge clk);
    rd(`ADDR_COUNT_LOW); `CHK(d, c0 + 8'h02)
    wr(`ADDR_WATCHDOG_CLEAR, 8'h00);
    wr(`ADDR_STATUS_CONTROL, 8'h2c);
    rd(`ADDR_STATUS_CONTROL); `CHK(d, 8'h20)
    repeat (1030) @(posedge clk);
    rd(`ADDR_STATUS_CONTROL); `CHK(d, 8'ha0)
    `CHK(timer_irq, 1'b1)
    wr(`ADDR_STATUS_CONTROL, 8'h00); `CHK(timer_irq, 1'b0)
    rd(`ADDR_STATUS_CONTROL); `CHK(d, 8'h80)
    wr(`ADDR_STATUS_CONTROL, 8'h08);
    rd(`ADDR_STATUS_CONTROL); `CHK(d, 8'h00)
    wr(`ADDR_IRQ_MASK, 8'h03);
    repeat (1030) @(posedge clk);
    `CHK(irq, 1'b1)
    rd(`ADDR_IRQ_MASK); `CHK(d, 8'h26)
    `CHK(irq, 1'b0)
    wr(`ADDR_IRQ_MASK, 8'h00);
    wr(`ADDR_WATCHDOG_CLEAR, 8'h00);
    wr(`ADDR_STATUS_CONTROL, 8'h10);
    repeat (16400) @(posedge clk);
    `CHK(irq, 1'b0)
    rd(`ADDR_STATUS_CONTROL); `CHK(d & 8'h7f, 8'h50)
    `CHK(timer_irq, 1'b1)
    wr(`ADDR_STATUS_CONTROL, 8'h14);
    rd(`ADDR_STATUS_CONTROL); `CHK(d & 8'h7f, 8'h10)
    rd(`ADDR_WATCHDOG_CLEAR); `CHK(d, 8'haa)
    rd(16'h0100); `CHK(d, 8'h00)
    `CHK(watchdog_reset, 1'b0)
    @(posedge clk) halt_req <= 1'b1;
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// *** testbench/timer_checker.sv ***
/*
 Port assertions for the multifunction timer.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "timer_defines.vh"
`default_nettype none
module timer_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rdata,
  input wire logic [7:0]  rom_data,
  input wire logic        irq,
  input wire logic        timer_irq,
  input wire logic        watchdog_reset,
  input wire logic        por_busy
);
  logic [12:0] por_cnt;
  always_ff @(posedge clk) begin
    if (rst) por_cnt <= 13'h0000;
    else if (por_busy) por_cnt <= por_cnt + 13'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data not idle");
  a_clear_bits: assert property ($past(rd_en) && $past(addr) == `ADDR_STATUS_CONTROL
    |-> rdata[3:2] == 2'h0) else $error("flag clear bits read nonzero");
  a_rom_read: assert property ($past(rd_en) && $past(addr) == `ADDR_WATCHDOG_CLEAR
    |-> rdata == $past(rom_data)) else $error("watchdog address read wrong");
  a_irq_enable: assert property (wr_en && addr == `ADDR_STATUS_CONTROL && wdata[5:4] == 2'h0
    |=> !timer_irq) else $error("timer interrupt with enables off");
  a_wdog_pulse: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  a_wdog_clear: assert property (wr_en && addr == `ADDR_WATCHDOG_CLEAR && !wdata[0]
    |-> ##2 !watchdog_reset [*8]) else $error("watchdog reset after clear");
  a_por_length: assert property ($fell(por_busy) |-> por_cnt == 13'h0fe0)
    else $error("power-on span wrong");
  a_por_quiet: assert property (por_busy |-> !timer_irq && !irq)
    else $error("interrupt during power-on");
  c_status_read: cover property (rd_en && addr == `ADDR_STATUS_CONTROL);
  c_timer_irq: cover property ($rose(timer_irq));
  c_wdog_clear: cover property (wr_en && addr == `ADDR_WATCHDOG_CLEAR);
endmodule
bind multifunction_timer_watchdog timer_checker i_chk (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rom_data(rom_data),
  .irq(irq), .timer_irq(timer_irq), .watchdog_reset(watchdog_reset), .por_busy(por_busy));
`default_nettype wire
